/* include/mctp_map.svh */
// constants of the match/capture timer with pwm: widths, codes, resets
`ifndef MCTP_MAP_SVH
`define MCTP_MAP_SVH

`define MCTP_CNT_W 32
`define MCTP_NUM_MATCH 7
`define MCTP_NUM_CAP 4
`define MCTP_NUM_EXT 4
`define MCTP_NUM_FLAG 11
`define MCTP_CNT_ZERO 32'h0
`define MCTP_CNT_ONE 32'h1

// external match output action codes
`define MCTP_EM_NONE 2'h0
`define MCTP_EM_LOW 2'h1
`define MCTP_EM_HIGH 2'h2
`define MCTP_EM_TOGGLE 2'h3

// count source codes
`define MCTP_CM_TIMER 2'h0
`define MCTP_CM_RISE 2'h1
`define MCTP_CM_FALL 2'h2
`define MCTP_CM_BOTH 2'h3

`define MCTP_CAP_NONE 4'h0
`define MCTP_CAP_ONE 4'h1

`endif

/* include/mctp_pkg.sv */
// types of the match/capture timer with pwm
package mctp_pkg;
`include "mctp_map.svh"

   // whole state of the timer core
   typedef struct packed {
      logic [`MCTP_CNT_W-1:0] count; // timer counter
      logic [`MCTP_CNT_W-1:0] pre; // prescale counter
      logic stopped; // halted by a stop match
      logic [`MCTP_NUM_MATCH-1:0][`MCTP_CNT_W-1:0] match; // active values
      logic [`MCTP_NUM_MATCH-1:0][`MCTP_CNT_W-1:0] shadow; // written values
      logic [`MCTP_NUM_MATCH-1:0] pend; // released, awaiting cycle end
      logic [`MCTP_NUM_EXT-1:0] ext; // external match outputs
      logic [`MCTP_NUM_MATCH-1:1] pwm; // pwm output levels
      logic [`MCTP_NUM_FLAG-1:0] flags; // sticky event flags
   } mctp_state_type;

   // whole state of the capture unit
   typedef struct packed {
      logic primed; // one sample taken since reset
      logic [`MCTP_NUM_CAP-1:0] prev; // previous input sample
      logic [`MCTP_NUM_CAP-1:0][`MCTP_CNT_W-1:0] value; // captured counts
   } mctp_cap_state_type;

endpackage

/* include/mctp_cap_if.sv */
// link between timer core and capture unit
`include "mctp_map.svh"
interface mctp_cap_if;
   import mctp_pkg::*;
   logic [`MCTP_CNT_W-1:0] count; // live counter value
   logic [`MCTP_NUM_CAP-1:0] rise_en; // capture on rising edge
   logic [`MCTP_NUM_CAP-1:0] fall_en; // capture on falling edge
   logic [`MCTP_NUM_CAP-1:0] edge_rise; // rising edge seen
   logic [`MCTP_NUM_CAP-1:0] edge_fall; // falling edge seen
   logic [`MCTP_NUM_CAP-1:0] event_hit; // capture taken this cycle
   logic [`MCTP_NUM_CAP-1:0][`MCTP_CNT_W-1:0] value; // capture registers

   modport core (output count, output rise_en, output fall_en,
      input edge_rise, input edge_fall, input event_hit, input value);
   modport capture (input count, input rise_en, input fall_en,
      output edge_rise, output edge_fall, output event_hit, output value);
endinterface

/* hw/mctp_capture.sv */
// capture unit: edge detection and capture registers per channel
`include "mctp_map.svh"
module mctp_capture
   import mctp_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic [`MCTP_NUM_CAP-1:0] capture_input, // capture pins
   mctp_cap_if.capture cap // link to timer core
);

   mctp_cap_state_type st; // current state
   mctp_cap_state_type next_st; // next state
   wire [`MCTP_NUM_CAP-1:0] rise_w; // per channel rising edge
   wire [`MCTP_NUM_CAP-1:0] fall_w; // per channel falling edge
   wire [`MCTP_NUM_CAP-1:0] hit_w; // per channel capture event

   //////////////////////////////////////////////////////////////////////
   // per channel edge and event decode
   genvar ch;
   generate
      for (ch = 0; ch < `MCTP_NUM_CAP; ch++) begin : g_ch
         assign rise_w[ch] = st.primed & ~st.prev[ch] & capture_input[ch];
         assign fall_w[ch] = st.primed & st.prev[ch] & ~capture_input[ch];
         assign hit_w[ch] = (rise_w[ch] & cap.rise_en[ch]) |
            (fall_w[ch] & cap.fall_en[ch]);
      end
   endgenerate

   assign cap.edge_rise = rise_w;
   assign cap.edge_fall = fall_w;
   assign cap.event_hit = hit_w;
   assign cap.value = st.value;

   //////////////////////////////////////////////////////////////////////
   // next state: sample pins, copy counter on events
   always_comb begin
      next_st = st;
      next_st.primed = 1'b1;
      next_st.prev = capture_input;
      for (int i = 0; i < `MCTP_NUM_CAP; i++) begin
         if (hit_w[i]) begin
            next_st.value[i] = cap.count;
         end
      end
   end

   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st.primed <= 1'b0; // first sample after reset is no edge
         st.prev <= `MCTP_CAP_NONE;
         st.value <= '0;
      end else begin
         st <= next_st;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_cap_copy: assert property (
      hit_w[0] |=> st.value[0] == $past(cap.count))
      else $error("capture 0 did not copy the counter");
   a_cap_mask: assert property (
      rise_w[1] && !cap.rise_en[1] && !fall_w[1] |=> $stable(st.value[1]))
      else $error("disabled capture 1 changed its register");

endmodule

/* hw/mctp_timer_pwm.sv */
// timer/counter with prescaler, match actions, capture and pwm outputs
`include "mctp_map.svh"
module mctp_timer_pwm
   import mctp_pkg::*;
(
   input wire logic ref_clk, // clock, 25 MHz
   input wire logic rst_n, // sync reset
   input wire logic cnt_en, // counter enable
   input wire logic cnt_clear, // hold counters at zero
   input wire logic [`MCTP_CNT_W-1:0] pre_limit, // prescale terminal value
   input wire logic [1:0] count_mode, // count source code
   input wire logic [1:0] count_sel, // capture input used as clock
   input wire logic [`MCTP_NUM_CAP-1:0] capture_input, // capture pins
   input wire logic [`MCTP_NUM_CAP-1:0] cap_rise_en, // capture on rise
   input wire logic [`MCTP_NUM_CAP-1:0] cap_fall_en, // capture on fall
   input wire logic [`MCTP_NUM_MATCH-1:0] match_wr, // match write strobes
   input wire logic [`MCTP_CNT_W-1:0] match_wdata, // match write value
   input wire logic [`MCTP_NUM_MATCH-1:0] match_release, // release strobes
   input wire logic [`MCTP_NUM_MATCH-1:0] match_reset_en, // reset on match
   input wire logic [`MCTP_NUM_MATCH-1:0] match_stop_en, // stop on match
   input wire logic [2*`MCTP_NUM_EXT-1:0] ext_match_cfg, // 2 bits per output
   input wire logic pwm_mode, // pwm mode on
   input wire logic [`MCTP_NUM_MATCH-1:2] pwm_dbl_sel, // double edge select
   input wire logic [`MCTP_NUM_MATCH-1:1] pwm_out_en, // pwm output enables
   input wire logic [`MCTP_NUM_FLAG-1:0] irq_enable, // flag enables
   input wire logic [`MCTP_NUM_FLAG-1:0] irq_clear, // flag clear strobes
   output logic [`MCTP_CNT_W-1:0] count, // counter value
   output logic [`MCTP_NUM_CAP-1:0][`MCTP_CNT_W-1:0] capture_value, // caps
   output logic [`MCTP_NUM_EXT-1:0] ext_match, // external match outputs
   output logic [`MCTP_NUM_MATCH-1:1] pwm_out, // pwm outputs
   output logic [`MCTP_NUM_FLAG-1:0] irq_flags, // sticky flags
   output logic irq // interrupt request
);

   mctp_state_type st; // current state
   mctp_state_type next_st; // next state
   mctp_cap_if cap_bus(); // capture link
   logic run; // counting allowed
   logic src; // raw count source event
   logic src_evt; // gated count source event
   logic tick; // prescaler terminal, counter steps
   logic [`MCTP_NUM_MATCH-1:0] hit; // match events this tick
   logic rst_hit; // some match resets the counter
   logic stop_hit; // some match stops the counter
   logic [`MCTP_NUM_CAP-1:0] clk_mask; // input serving as count clock
   logic [`MCTP_NUM_MATCH-1:1] dbl_sel; // double edge select, ch1 single

   // channel 1 has no lower match to rise on, so it is always single edge
   assign dbl_sel = {pwm_dbl_sel, 1'b0};

   //////////////////////////////////////////////////////////////////////
   // capture unit
   mctp_capture u_capture (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .capture_input(capture_input),
      .cap(cap_bus.capture)
   );

   // clock input does not capture, the others keep working
   always_comb begin
      clk_mask = `MCTP_CAP_NONE;
      if (count_mode != `MCTP_CM_TIMER) begin
         clk_mask = `MCTP_CAP_ONE << count_sel;
      end
   end

   assign cap_bus.count = st.count;
   assign cap_bus.rise_en = cap_rise_en & ~clk_mask;
   assign cap_bus.fall_en = cap_fall_en & ~clk_mask;

   //////////////////////////////////////////////////////////////////////
   // count source and match decode
   always_comb begin
      run = cnt_en && !st.stopped && !cnt_clear;
      // pins are sampled each clock, so an external clock counts only
      // while its levels each last at least one sample
      unique case (count_mode)
         `MCTP_CM_TIMER: src = 1'b1;
         `MCTP_CM_RISE: src = cap_bus.edge_rise[count_sel];
         `MCTP_CM_FALL: src = cap_bus.edge_fall[count_sel];
         `MCTP_CM_BOTH: src = cap_bus.edge_rise[count_sel] |
            cap_bus.edge_fall[count_sel];
      endcase
      src_evt = run && src;
      tick = src_evt && (st.pre == pre_limit);
      for (int i = 0; i < `MCTP_NUM_MATCH; i++) begin
         hit[i] = tick && (st.count == st.match[i]);
      end
      // cycle match always ends the period in pwm mode
      rst_hit = (|(hit & match_reset_en)) || (pwm_mode && hit[0]);
      stop_hit = |(hit & match_stop_en);
   end

   //////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      next_st = st;
      // prescaler
      if (cnt_clear) begin
         next_st.pre = `MCTP_CNT_ZERO;
      end else if (src_evt) begin
         next_st.pre = tick ? `MCTP_CNT_ZERO : st.pre + `MCTP_CNT_ONE;
      end
      // counter
      if (cnt_clear) begin
         next_st.count = `MCTP_CNT_ZERO;
      end else if (tick) begin
         // any whole number of ticks sets the period
         next_st.count = rst_hit ? `MCTP_CNT_ZERO
            : st.count + `MCTP_CNT_ONE;
      end
      // stop latch, cleared by dropping the enable
      if (!cnt_en) begin
         next_st.stopped = 1'b0;
      end else if (stop_hit) begin
         next_st.stopped = 1'b1;
      end
      // released shadows become active at the cycle end
      if (pwm_mode && hit[0]) begin
         for (int i = 0; i < `MCTP_NUM_MATCH; i++) begin
            if (st.pend[i]) begin
               next_st.match[i] = st.shadow[i];
            end
         end
         next_st.pend = '0;
      end
      // writes: direct as a timer, shadowed in pwm mode
      for (int i = 0; i < `MCTP_NUM_MATCH; i++) begin
         if (match_wr[i]) begin
            next_st.shadow[i] = match_wdata;
            if (!pwm_mode) begin
               next_st.match[i] = match_wdata;
            end
         end
         if (match_release[i]) begin
            next_st.pend[i] = 1'b1;
         end
      end
      // external match outputs
      for (int j = 0; j < `MCTP_NUM_EXT; j++) begin
         if (hit[j]) begin
            unique case (ext_match_cfg[2*j +: 2])
               `MCTP_EM_NONE: next_st.ext[j] = st.ext[j];
               `MCTP_EM_LOW: next_st.ext[j] = 1'b0;
               `MCTP_EM_HIGH: next_st.ext[j] = 1'b1;
               `MCTP_EM_TOGGLE: next_st.ext[j] = ~st.ext[j];
            endcase
         end
      end
      // pwm outputs; a fall on the same tick as the rise wins
      for (int n = 1; n < `MCTP_NUM_MATCH; n++) begin
         if (!pwm_mode) begin
            next_st.pwm[n] = 1'b0;
         end else if (hit[n]) begin
            next_st.pwm[n] = 1'b0;
         end else if (dbl_sel[n]) begin
            if (hit[n-1]) begin
               next_st.pwm[n] = 1'b1;
            end
         end else if (hit[0]) begin
            next_st.pwm[n] = 1'b1;
         end
      end
      // sticky flags: a new event wins over a clear
      next_st.flags = (st.flags & ~irq_clear) |
         {cap_bus.event_hit, hit};
   end

   //////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // outputs
   assign count = st.count;
   assign capture_value = cap_bus.value;
   assign ext_match = st.ext;
   assign pwm_out = st.pwm & pwm_out_en;
   assign irq_flags = st.flags;
   assign irq = |(st.flags & irq_enable);

   //////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // period ends on a pwm cycle match
   sequence s_cycle_end;
      pwm_mode && hit[0];
   endsequence

   // match 1 released and waiting
   sequence s_released;
      pwm_mode && st.pend[1];
   endsequence

   // a stop match taken while counting stays enabled
   sequence s_stop_seen;
      stop_hit && !cnt_clear;
   endsequence

   a_pre_step: assert property (
      src_evt && !tick |=> st.pre == $past(st.pre) + `MCTP_CNT_ONE)
      else $error("prescaler did not step");
   a_count_step: assert property (
      tick && !rst_hit |=> st.count == $past(st.count) + `MCTP_CNT_ONE)
      else $error("counter did not step on tick");
   a_stop_holds: assert property (
      s_stop_seen ##1 (cnt_en && !cnt_clear) |=> $stable(st.count))
      else $error("counter moved after stop match");
   a_ext_toggle: assert property (
      hit[0] && ext_match_cfg[1:0] == `MCTP_EM_TOGGLE
      |=> st.ext[0] != $past(st.ext[0]))
      else $error("match output 0 did not toggle");
   a_cycle_reset: assert property (
      s_cycle_end |=> st.count == `MCTP_CNT_ZERO)
      else $error("cycle match did not reset count");
   a_single_rise: assert property (
      s_cycle_end ##0 !hit[1] |=> st.pwm[1])
      else $error("single edge output did not rise");
   a_dbl_fall: assert property (
      pwm_mode && pwm_dbl_sel[3] && hit[3] |=> !st.pwm[3])
      else $error("double edge output did not fall");
   a_dbl_rise: assert property (
      pwm_mode && pwm_dbl_sel[3] && hit[2] && !hit[3] |=> st.pwm[3])
      else $error("double edge output did not rise");
   a_release_apply: assert property (
      s_released ##0 s_cycle_end |=> st.match[1] == $past(st.shadow[1]))
      else $error("released value not applied at cycle end");
   a_unreleased_hold: assert property (
      pwm_mode && !st.pend[1] |=> $stable(st.match[1]))
      else $error("unreleased match value took effect");
   a_flag_sticky: assert property (
      (hit[0] || (st.flags[0] && !irq_clear[0])) |=> st.flags[0])
      else $error("match flag lost");

   // counter holds between ticks
   a_cnt_hold: assert property (
      !tick && !cnt_clear |=> $stable(st.count))
      else $error("counter moved without a tick");

   // clear zeroes counter and prescaler
   a_cnt_clear: assert property (
      cnt_clear |=> st.count == `MCTP_CNT_ZERO && st.pre == `MCTP_CNT_ZERO)
      else $error("clear did not zero the counters");

   // prescaler restarts on every tick
   a_pre_wrap: assert property (
      tick |=> st.pre == `MCTP_CNT_ZERO)
      else $error("prescaler did not restart");

   // reset action on any match
   a_match_reset: assert property (
      |(hit & match_reset_en) |=> st.count == `MCTP_CNT_ZERO)
      else $error("reset match did not zero count");

   // stop action latches the halt
   a_stop_latch: assert property (
      stop_hit |=> st.stopped)
      else $error("stop match did not halt");

   // output 0 driven high by its match
   a_ext_high: assert property (
      hit[0] && ext_match_cfg[1:0] == `MCTP_EM_HIGH |=> st.ext[0])
      else $error("match output 0 did not go high");

   // output 0 driven low by its match
   a_ext_low: assert property (
      hit[0] && ext_match_cfg[1:0] == `MCTP_EM_LOW |=> !st.ext[0])
      else $error("match output 0 did not go low");

   // output 3 left alone by its match
   a_ext_none: assert property (
      hit[3] && ext_match_cfg[7:6] == `MCTP_EM_NONE |=> $stable(st.ext[3]))
      else $error("match output 3 changed");

   // the count clock input never captures
   a_clk_masked: assert property (
      count_mode != `MCTP_CM_TIMER |-> !cap_bus.event_hit[count_sel])
      else $error("count clock input captured");

   // capture event on input 1 sets its flag
   a_flag_capture: assert property (
      cap_bus.event_hit[1] |=> st.flags[`MCTP_NUM_MATCH + 1])
      else $error("capture 1 flag not set");

   // pwm levels rest low as a plain timer
   a_pwm_idle: assert property (
      !pwm_mode |=> st.pwm == '0)
      else $error("pwm level set outside pwm mode");

   // plain timer writes take effect at once
   a_timer_write: assert property (
      !pwm_mode && match_wr[1] |=> st.match[1] == $past(match_wdata))
      else $error("timer write to match 1 not direct");

endmodule

/* sim/mctp_tb.sv */
// self-checking bench for the match/capture timer with pwm
module tb
   import mctp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // one prescaler row: terminal value, cycles run, count expected
   typedef struct {
      logic [31:0] pre;
      int cyc;
      logic [31:0] exp;
   } mctp_row_type;

   logic ref_clk = 1'b0; // 25 MHz clock
   logic rst_n = 1'b0; // sync reset
   logic cnt_en = 1'b0, cnt_clear = 1'b0; // counter control
   logic [31:0] pre_limit = 32'h0, match_wdata = 32'h0; // values
   logic [1:0] count_mode = 2'h0, count_sel = 2'h0; // count source
   logic [3:0] capture_input = 4'h0; // capture pins
   logic [3:0] cap_rise_en = 4'h0, cap_fall_en = 4'h0; // edge enables
   logic [6:0] match_wr = 7'h0, match_release = 7'h0; // strobes
   logic [6:0] match_reset_en = 7'h0, match_stop_en = 7'h0; // actions
   logic [7:0] ext_match_cfg = 8'h0; // output actions
   logic pwm_mode = 1'b0; // pwm mode
   logic [6:2] pwm_dbl_sel = 5'h0; // double edge select
   logic [6:1] pwm_out_en = 6'h0; // pwm enables
   logic [10:0] irq_enable = 11'h0, irq_clear = 11'h0; // flag control
   logic [31:0] count; // counter seen
   logic [3:0][31:0] capture_value; // capture registers seen
   logic [3:0] ext_match; // match outputs seen
   logic [6:1] pwm_out; // pwm outputs seen
   logic [10:0] irq_flags; // flags seen
   logic irq; // request seen
   int num_errors = 0, total_checks = 0; // report counters
   int i, k; // loop indices
   logic [31:0] c; // sampled count
   mctp_row_type rows [4] = '{'{32'h0, 5, 32'h5}, '{32'h1, 7, 32'h3},
      '{32'h3, 9, 32'h2}, '{32'h2, 12, 32'h4}}; // prescaler cases

   mctp_timer_pwm i_dut (.*);

   // free running clock
   always #20 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   // wait n edges, then settle
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // zero the counters and all flags
   task automatic clr();
      @(posedge ref_clk);
      cnt_clear <= 1'b1;
      irq_clear <= 11'h7FF;
      @(posedge ref_clk);
      cnt_clear <= 1'b0;
      irq_clear <= 11'h0;
   endtask

   // one-cycle match write, with optional release
   task automatic wr(int n, logic [31:0] v, logic rel);
      @(posedge ref_clk);
      match_wr[n] <= 1'b1;
      match_wdata <= v;
      match_release[n] <= rel;
      @(posedge ref_clk);
      match_wr <= 7'h0;
      match_release <= 7'h0;
   endtask

   // one pwm period from count 0: ch1 high to w, ch3 per mask
   task automatic pwm_chk(int w, logic [4:0] m3);
      int n;
      n = 0;
      while (count !== 32'h0 && n < 10) begin
         cyc(1);
         n++;
      end
      for (n = 0; n < 5; n++) begin
         chk("pwm count", n, count);
         chk("pwm out", {3'h0, m3[n], 1'b0, n <= w}, pwm_out);
         cyc(1);
      end
   endtask

   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // cut a hang short
   initial begin
      repeat (3000) @(posedge ref_clk);
      num_errors++;
      results();
   end

   ////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      cyc(9);
      chk("reset outs", 0, {irq, irq_flags, pwm_out, ext_match});
      chk("reset count", 0, count);
      chk("reset caps", 0, capture_value[0] | capture_value[1] |
         capture_value[2] | capture_value[3]);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      cnt_en <= 1'b1;
      $display("test reset done");
      // prescaler table
      foreach (rows[r]) begin
         clr();
         pre_limit <= rows[r].pre;
         cyc(rows[r].cyc);
         chk("count", rows[r].exp, count);
         chk("pwm idle", 0, pwm_out);
      end
      $display("test prescaler done");
      // match actions on the four outputs, every code
      pre_limit <= 32'h0;
      for (i = 0; i < 4; i++)
         wr(i, i + 1, 1'b0);
      match_reset_en <= 7'h8;
      ext_match_cfg <= 8'h2E;
      clr();
      cyc(5);
      chk("ext high toggle", 4'h7, ext_match);
      chk("count wrap", 0, count);
      @(posedge ref_clk);
      ext_match_cfg <= 8'h8D;
      cyc(4);
      chk("ext low none", 4'hC, ext_match);
      chk("count wrap", 0, count);
      // sticky flags and request
      @(posedge ref_clk);
      cnt_en <= 1'b0;
      irq_enable <= 11'h1;
      cyc(1);
      chk("irq on", 1, irq);
      chk("match flags", 4'hF, irq_flags[3:0]);
      @(posedge ref_clk);
      irq_clear <= 11'h1;
      @(posedge ref_clk);
      irq_clear <= 11'h0;
      #1;
      chk("irq cleared", 2'h2, {irq_flags[1:0]});
      chk("irq off", 0, irq);
      @(posedge ref_clk);
      irq_enable <= 11'h2;
      #1;
      chk("irq other", 1, irq);
      $display("test match done");
      // stop on match
      match_reset_en <= 7'h0;
      match_stop_en <= 7'h4;
      cnt_en <= 1'b1;
      clr();
      cyc(8);
      c = count;
      cyc(10);
      chk("stop hold", c, count);
      chk("stop place", 1, 32'(c < 5));
      $display("test stop done");
      // external count on input 0, on input 3 last; capture on input 1, and on input 0 when free
      for (k = 1; k < 4; k++) begin
         @(posedge ref_clk);
         cnt_en <= 1'b0;
         match_stop_en <= 7'h0;
         count_mode <= 2'(k);
         count_sel <= {k == 3, k == 3}; // clock on input 3 last
         cap_rise_en <= 4'h3;
         @(posedge ref_clk);
         cnt_en <= 1'b1;
         clr();
         for (i = 0; i < 5; i++) begin
            capture_input <= {k == 3, 1'b0, i == 2, 1'b1};
            repeat (2) @(posedge ref_clk);
            capture_input <= 4'h0;
            repeat (2) @(posedge ref_clk);
         end
         cyc(2);
         chk("ext count", (k == 3) ? 10 : 5, count);
         chk("cap other", (k == 3) ? 4 : 2, capture_value[1]);
         chk("cap flags", (k == 3) ? 3 : 2, irq_flags[8:7]);
         chk("cap ch0", (k == 3) ? 8 : 0, capture_value[0]);
      end
      $display("test counter done");
      // falling edge capture in timer mode
      @(posedge ref_clk);
      count_mode <= 2'h0;
      cap_rise_en <= 4'h0;
      cap_fall_en <= 4'h4;
      capture_input[2:1] <= 2'h3; // rise on 1 is not armed
      cyc(3);
      @(posedge ref_clk);
      capture_input[2:1] <= 2'h0;
      #1;
      c = count;
      cyc(2);
      chk("cap fall", c, capture_value[2]);
      chk("cap flag", 1, irq_flags[9]);
      chk("cap masked", 4, capture_value[1]);
      $display("test capture done");
      // pwm: ch1 single, ch3 double, ch2 gated off
      @(posedge ref_clk);
      pwm_mode <= 1'b1;
      pwm_dbl_sel <= 5'h2;
      pwm_out_en <= 6'h5;
      wr(0, 4, 1'b1);
      wr(1, 2, 1'b1);
      wr(2, 1, 1'b1);
      wr(3, 3, 1'b1);
      clr(); // start the period from zero
      cyc(12);
      pwm_chk(2, 5'h0C);
      wr(1, 1, 1'b0);
      cyc(12);
      pwm_chk(2, 5'h0C);
      wr(1, 1, 1'b1);
      wr(2, 3, 1'b1);
      wr(3, 1, 1'b1);
      cyc(12);
      pwm_chk(1, 5'h13);
      $display("test pwm done");
      // reset in mid-run
      @(posedge ref_clk);
      rst_n <= 1'b0;
      @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("rerun outs", 0, {irq, irq_flags, pwm_out, ext_match});
      chk("rerun count", 0, count);
      $display("test rerun done");
      results();
   end
endmodule
